// File: rtl/wdg_core.sv
// Watchdog timer core: 24-bit down-counter, register port and timeout response
//
// Overview of operation
// - First enable presets the counter from the reload register before counting.
// - Once loaded, the counter decrements until it reaches zero or is refreshed.
// - While enabled, each refresh instruction reloads the counter; counting continues from there.
// - In debug mode the counter is refreshed every cycle, so no timeout occurs.
// - A timeout is recognised when the counter reaches zero.
// - A non-volatile option selects interrupt or short reset as timeout response.
// - Interrupt response raises an interrupt request and sets the timeout flag.
// - After an interrupt-mode timeout the counter wraps to all ones, no reload.
// - Interrupt response in stop mode also starts stop-mode recovery.
// - An interrupt-mode timeout in stop mode sets both the timeout flag and the stop flag.
`timescale 1ns/10ps
`default_nettype none
`include "wdg_map.svh"

module wdg_core (
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	input  wire wdg_pkg::wdg_bus_req_t   bus_req,
	output logic [`WDG_DATA_W-1:0]       rd_data,
	input  wire logic                    refresh_exec,
	input  wire logic                    debug_mode,
	input  wire logic                    stop_mode,
	input  wire logic                    timeout_response_select,
	input  wire logic                    watchdog_osc,
	output wdg_pkg::wdg_evt_t            events
);
	import wdg_pkg::*;

	wdg_core_state_t            s_q;
	wdg_core_state_t            s_d;
	logic                       osc_tick;
	logic                       debug_mode_m_q;
	logic                       debug_mode_s_q;
	logic                       stop_mode_m_q;
	logic                       stop_mode_s_q;
	logic                       wr_ctrl;
	logic                       wr_reload;
	logic                       first_enable;
	logic                       timeout;
	logic                       refresh_now;

	// The oscillator is asynchronous to core_clk; it must run below half the core rate
	wdg_osc_sync u_osc_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.osc_in   (watchdog_osc),
		.osc_rise (osc_tick)
	);

	// Debug and stop levels come from other clocking; two flops before use
	always_ff @(posedge core_clk) begin
		if (reset) begin
			debug_mode_m_q <= 1'b0;
			debug_mode_s_q <= 1'b0;
			stop_mode_m_q  <= 1'b0;
			stop_mode_s_q  <= 1'b0;
		end else begin
			debug_mode_m_q <= debug_mode;
			debug_mode_s_q <= debug_mode_m_q;
			stop_mode_m_q  <= stop_mode;
			stop_mode_s_q  <= stop_mode_m_q;
		end
	end

	assign wr_ctrl      = bus_req.wr && (bus_req.addr == `WDG_CTRL_OFS);
	assign wr_reload    = bus_req.wr && (bus_req.addr == `WDG_RELOAD_OFS);
	assign first_enable = wr_ctrl && bus_req.wdata[`WDG_CTRL_EN_BIT] && !s_q.enable;
	assign refresh_now  = debug_mode_s_q || (refresh_exec && s_q.enable);

	always_comb begin
		s_d               = s_q;
		s_d.rd_data       = '0;
		s_d.irq_req       = 1'b0;
		s_d.stop_recovery = 1'b0;
		timeout           = 1'b0;

		// Option bit is taken once, in the first cycle after reset is released
		if (!s_q.rsp_valid) begin
			s_d.rsp_sel   = timeout_response_select;
			s_d.rsp_valid = 1'b1;
		end

		// Register writes; status flags clear by writing one
		if (wr_ctrl) begin
			s_d.enable = bus_req.wdata[`WDG_CTRL_EN_BIT];
			if (bus_req.wdata[`WDG_CTRL_TMO_BIT]) begin
				s_d.tmo_flag = 1'b0;
			end
			if (bus_req.wdata[`WDG_CTRL_STOP_BIT]) begin
				s_d.stop_flag = 1'b0;
			end
		end
		if (wr_reload) begin
			s_d.reload = bus_req.wdata[`WDG_CNT_W-1:0];
		end

		// Counter: refresh beats enable load beats a tick
		if (refresh_now) begin
			s_d.count = s_q.reload;
		end else if (first_enable) begin
			s_d.count = s_q.reload;
		end else if (s_q.enable && osc_tick) begin
			// Zero wraps to full scale by plain decrement, never to the reload value
			s_d.count = s_q.count - `WDG_ONE;
			timeout   = (s_q.count == `WDG_ONE);
		end

		// Short reset stretch runs down one per core cycle
		if (s_q.srst_cnt != '0) begin
			s_d.srst_cnt = s_q.srst_cnt - 4'h1;
		end

		// Timeout response; sets come after clears so an event is never lost
		if (timeout) begin
			if (s_q.rsp_sel == `WDG_RSP_IRQ) begin
				s_d.irq_req  = 1'b1;
				s_d.tmo_flag = 1'b1;
				if (stop_mode_s_q) begin
					s_d.stop_recovery = 1'b1;
					s_d.stop_flag     = 1'b1;
				end
			end else begin
				s_d.srst_cnt = `WDG_SRST_CYCLES;
			end
		end

		// Read data stand only in the cycle after the read strobe
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`WDG_CTRL_OFS: begin
					s_d.rd_data[`WDG_CTRL_EN_BIT]   = s_q.enable;
					s_d.rd_data[`WDG_CTRL_RSP_BIT]  = s_q.rsp_sel;
					s_d.rd_data[`WDG_CTRL_TMO_BIT]  = s_q.tmo_flag;
					s_d.rd_data[`WDG_CTRL_STOP_BIT] = s_q.stop_flag;
				end
				`WDG_RELOAD_OFS: begin
					s_d.rd_data[`WDG_CNT_W-1:0] = s_q.reload;
				end
				`WDG_COUNT_OFS: begin
					s_d.rd_data[`WDG_CNT_W-1:0] = s_q.count;
				end
				default: begin
					s_d.rd_data = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q        <= '0;
			s_q.reload <= `WDG_RELOAD_RST;
			s_q.count  <= `WDG_RELOAD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data              = s_q.rd_data;
	assign events.irq_req       = s_q.irq_req;
	assign events.stop_recovery = s_q.stop_recovery;
	assign events.short_reset   = (s_q.srst_cnt != '0);

endmodule

`default_nettype wire

// File: rtl/wdg_map.svh
// Register offsets, field positions, reset values and counts of the watchdog
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

`define WDG_CNT_W          24
`define WDG_ADDR_W         8
`define WDG_DATA_W         32
`define WDG_SRST_W         4

`define WDG_CTRL_OFS       8'h00
`define WDG_RELOAD_OFS     8'h04
`define WDG_COUNT_OFS      8'h08

`define WDG_CTRL_EN_BIT    0
`define WDG_CTRL_RSP_BIT   1
`define WDG_CTRL_TMO_BIT   4
`define WDG_CTRL_STOP_BIT  5

`define WDG_RELOAD_RST     24'h00FFFF
`define WDG_FULL_SCALE     24'hFFFFFF
`define WDG_ZERO           24'h000000
`define WDG_ONE            24'h000001
`define WDG_MIN_RELOAD     24'h000004

`define WDG_RSP_IRQ        1'b0
`define WDG_RSP_RESET      1'b1

`define WDG_SRST_CYCLES    4'h8

`endif

// File: rtl/wdg_pkg.sv
// Types shared by the watchdog design files
`include "wdg_map.svh"

package wdg_pkg;

	typedef struct packed {
		logic                     wr;
		logic                     rd;
		logic [`WDG_ADDR_W-1:0]   addr;
		logic [`WDG_DATA_W-1:0]   wdata;
	} wdg_bus_req_t;

	typedef struct packed {
		logic irq_req;
		logic short_reset;
		logic stop_recovery;
	} wdg_evt_t;

	typedef struct packed {
		logic                     enable;
		logic                     rsp_valid;
		logic                     rsp_sel;
		logic                     tmo_flag;
		logic                     stop_flag;
		logic                     irq_req;
		logic                     stop_recovery;
		logic [`WDG_SRST_W-1:0]   srst_cnt;
		logic [`WDG_CNT_W-1:0]    count;
		logic [`WDG_CNT_W-1:0]    reload;
		logic [`WDG_DATA_W-1:0]   rd_data;
	} wdg_core_state_t;

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
	} wdg_sync_state_t;

endpackage

// File: rtl/wdg_osc_sync.sv
// Two-flop synchroniser and rising-edge detector for the watchdog oscillator
`timescale 1ns/10ps
`default_nettype none

module wdg_osc_sync (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic osc_in,
	output logic      osc_rise
);
	import wdg_pkg::*;

	wdg_sync_state_t s_q;
	wdg_sync_state_t s_d;

	// Only the second stage feeds the edge detector; the first stage may be metastable
	always_comb begin
		s_d      = s_q;
		s_d.meta = osc_in;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.rise = s_q.sync & ~s_q.prev;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign osc_rise = s_q.rise;

endmodule

`default_nettype wire

// File: tb/wdg_far_end.sv
// Interrupt controller and reset logic as seen from the watchdog
`timescale 1ns/10ps
`default_nettype none
module wdg_far_end (
	input  wire logic              core_clk,
	input  wire wdg_pkg::wdg_evt_t events,
	output var int                 irq_seen,
	output var int                 recov_seen,
	output var int                 srst_cycles
);
	import wdg_pkg::*;
	initial begin
		irq_seen = 0;
		recov_seen = 0;
		srst_cycles = 0;
	end
	// Only counts; a real reset tree would also clear the core
	always @(posedge core_clk) begin
		irq_seen <= irq_seen + int'(events.irq_req === 1'b1);
		recov_seen <= recov_seen + int'(events.stop_recovery === 1'b1);
		srst_cycles <= srst_cycles + int'(events.short_reset === 1'b1);
	end
endmodule
`default_nettype wire

// File: tb/wdg_core_properties.sv
// Port-level checks of the watchdog core
`timescale 1ns/10ps
`default_nettype none
`include "wdg_map.svh"
module wdg_core_props (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire wdg_pkg::wdg_bus_req_t bus_req,
	input  wire logic [`WDG_DATA_W-1:0] rd_data,
	input  wire logic                  stop_mode,
	input  wire logic                  debug_mode,
	input  wire logic                  timeout_response_select,
	input  wire wdg_pkg::wdg_evt_t     events
);
	import wdg_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	irq_pulse_a: assert property (events.irq_req |=> !events.irq_req)
		else $error("irq wider than one cycle");
	srst_len_a: assert property ($rose(events.short_reset) |->
		events.short_reset[*8] ##1 !events.short_reset) else $error("short reset length");
	irq_mode_a: assert property (events.irq_req |-> !timeout_response_select)
		else $error("irq in reset mode");
	stop_pair_a: assert property (events.stop_recovery |-> events.irq_req)
		else $error("recovery without irq");
	stop_cause_a: assert property (events.stop_recovery |-> $past(stop_mode, 2))
		else $error("recovery outside stop");
	dbg_hold_a: assert property (debug_mode[*6] |-> !events.irq_req)
		else $error("timeout in debug");
	rd_upper_a: assert property ($past(bus_req.rd) |-> rd_data[31:24] == 8'h00)
		else $error("upper read bits set");
	opt_read_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == `WDG_CTRL_OFS |->
		rd_data[`WDG_CTRL_RSP_BIT] == timeout_response_select) else $error("option bit");
endmodule
bind wdg_core wdg_core_props u_props (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
	.rd_data(rd_data), .stop_mode(stop_mode), .debug_mode(debug_mode),
	.timeout_response_select(timeout_response_select), .events(events));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the watchdog core
`timescale 1ns/10ps
`default_nettype none
`include "wdg_map.svh"
module tb;
	import wdg_pkg::*;
	logic                   core_clk, reset, refresh_exec, debug_mode, stop_mode, opt, osc;
	wdg_bus_req_t           bus_req;
	wdg_evt_t               events;
	logic [`WDG_DATA_W-1:0] rd_data, v;
	int                     miscompares = 0, num_checks = 0, cycles = 0, irq_n, rec_n, srst_n;
	wdg_core DUT (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data),
		.refresh_exec(refresh_exec), .debug_mode(debug_mode), .stop_mode(stop_mode),
		.timeout_response_select(opt), .watchdog_osc(osc), .events(events));
	wdg_far_end u_far (.core_clk(core_clk), .events(events), .irq_seen(irq_n),
		.recov_seen(rec_n), .srst_cycles(srst_n));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk) bus_req.wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge core_clk) bus_req.rd <= 1'b0;
		#1 v = rd_data;
		chk(v, exp);
	endtask
	// Slow oscillator: each phase spans several core cycles so the synchroniser sees it
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk) osc <= 1'b1;
			repeat (4) @(posedge core_clk);
			osc <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask
	task automatic refresh();
		@(posedge core_clk) refresh_exec <= 1'b1;
		@(posedge core_clk) refresh_exec <= 1'b0;
	endtask
	task automatic do_reset(input logic o);
		@(posedge core_clk);
		reset <= 1'b1;
		opt <= o;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
	endtask
	task automatic t_load();
		rc(`WDG_RELOAD_OFS, 32'hFFFF);
		rc(8'h0C, 32'h0);
		wr(`WDG_RELOAD_OFS, 32'h4);
		wr(`WDG_CTRL_OFS, 32'h1);
		rc(`WDG_COUNT_OFS, 32'h4);
		tick(1);
		rc(`WDG_COUNT_OFS, 32'h3);
		refresh();
		rc(`WDG_COUNT_OFS, 32'h4);
	endtask
	task automatic t_irq();
		int n0;
		n0 = irq_n;
		tick(4);
		rc(`WDG_COUNT_OFS, 32'h0);
		chk(irq_n - n0, 32'h1);
		rc(`WDG_CTRL_OFS, 32'h11);
		tick(1);
		rc(`WDG_COUNT_OFS, 32'hFFFFFF);
		wr(`WDG_CTRL_OFS, 32'h11);
		rc(`WDG_CTRL_OFS, 32'h1);
	endtask
	task automatic t_stop();
		int r0;
		r0 = rec_n;
		@(posedge core_clk) stop_mode <= 1'b1;
		refresh();
		tick(4);
		chk(rec_n - r0, 32'h1);
		rc(`WDG_CTRL_OFS, 32'h31);
		@(posedge core_clk) stop_mode <= 1'b0;
		wr(`WDG_CTRL_OFS, 32'h31);
	endtask
	task automatic t_debug();
		int n0;
		n0 = irq_n;
		@(posedge core_clk) debug_mode <= 1'b1;
		tick(6);
		rc(`WDG_COUNT_OFS, 32'h4);
		chk(irq_n - n0, 32'h0);
		@(posedge core_clk) debug_mode <= 1'b0;
	endtask
	task automatic t_short();
		int s0;
		s0 = srst_n;
		do_reset(1'b1);
		wr(`WDG_RELOAD_OFS, 32'h4);
		wr(`WDG_CTRL_OFS, 32'h1);
		tick(4);
		repeat (10) @(posedge core_clk);
		chk(srst_n - s0, 32'h8);
		rc(`WDG_CTRL_OFS, 32'h3);
	endtask
	initial begin
		{refresh_exec, debug_mode, stop_mode, osc} = 4'h0;
		bus_req = '0;
		reset = 1'b1;
		opt = 1'b0;
		do_reset(1'b0);
		t_load();
		t_irq();
		t_stop();
		t_debug();
		t_short();
		print_verdict();
	end
endmodule
`default_nettype wire
